//--- hw/fisp_buf2.v
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Writer and reader share one clock.
// Notes: Full and empty are exact; a stalled reader lets it fill and drops in_ready.
`default_nettype none

module fisp_buf2 #(
  parameter WIDTH = 33
) (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Filling side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // Draining side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  // State
  output wire empty
);

  reg [WIDTH-1:0] mem_ff [0:1];
  reg wr_ptr_ff;
  reg rd_ptr_ff;
  reg [1:0] count_ff;
  wire push;
  wire pop;

  assign in_ready = (count_ff != 2'h2);
  assign out_valid = (count_ff != 2'h0);
  assign empty = (count_ff == 2'h0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Pointers and occupancy; storage is two entries picked by the write index.
  always @(posedge clk)
  begin
    if (reset)
    begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        mem_ff[wr_ptr_ff] <= in_data;
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop)
        rd_ptr_ff <= ~rd_ptr_ff;
      if (push && !pop)
        count_ff <= count_ff + 2'h1;
      else if (pop && !push)
        count_ff <= count_ff - 2'h1;
    end
  end

endmodule

`default_nettype wire

//--- hw/fisp_sync3.v
// Purpose: Three-stage synchroniser for a level from outside the clock domain.
// Assumes: The input changes slowly compared with the clock.
// Notes: The output follows only when the second and third stages agree.
`default_nettype none

module fisp_sync3 (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Level in and out
  input wire async_in,
  output reg sync_out
);

  reg s1_ff;
  reg s2_ff;
  reg s3_ff;

  // The first stage feeds only the second, so metastability never reaches the compare.
  always @(posedge clk)
  begin
    if (reset)
    begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff)
        sync_out <= s3_ff;
    end
  end

endmodule

`default_nettype wire

//--- hw/fisp_top.v
// Purpose: In-system page programmer for a 10K x 16 program flash, fed from data RAM.
// Assumes: Data RAM returns a byte one clock after a read enable; Avalon-MM byte addressing.
// Notes: Holds the CPU while busy; other peripherals keep their own clocks untouched.
//
// Implementation choice: register access over Avalon-MM.
`include "fisp_defs.vh"
`default_nettype none

module fisp_top (
  // Clock and reset
  input wire clk,
  input wire reset,
  // Avalon-MM register slave
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // Core stall
  output wire cpu_hold,
  // Lock option pin
  input wire boot_region_lock_option,
  // Data RAM read port
  output reg ram_rd_en,
  output reg [9:0] ram_rd_addr,
  input wire [7:0] ram_rd_data,
  // Flash array port
  output wire flash_valid,
  input wire flash_ready,
  output wire flash_erase,
  output wire [15:0] flash_addr,
  output wire [15:0] flash_wdata
);

  // Timing seen from outside, for whoever drives or models the far side.
  // Bus: every read or write gets exactly one wait cycle. A write lands at the first
  // edge of the request; read data are loaded there and still stand at the second.
  // Register writes made while the core is held are answered but change nothing beyond a refusal clear,
  // because the bus master is expected to be that same held core.
  // Program, per word: RD_LO and RD_HI each raise ram_rd_en for one cycle, at source
  // bytes X and X+1, and the RAM must return each byte in the following cycle.
  // CAP joins the pair, and PUSH hands the word to the buffer and steps the flash address and the words left.
  // A full buffer keeps PUSH waiting, so a slow flash only stretches the operation.
  // The last word leads to DRAIN, which waits for the buffer to empty before the
  // core is let go, so the core never resumes with a word still in flight.
  // Erase: a single entry with the erase flag and the page start; the flash array
  // is expected to clear the whole page on that one entry.
  // Refusal: a locked target never leaves idle, so cpu_hold stays low, and the
  // status flag records the refusal until software writes a one to clear it.
  // Limits: the start address is not checked for alignment, and bit 9 of the
  // start source address is always zero because only bit 8 has storage.
  // Status word: bit 0 busy, bit 1 refused, bit 2 synchronised lock option.
  // Hazard: the flash port must not see an entry change while it is stalled, so
  // the buffer keeps its head entry fixed until flash_ready is seen high.
  // Trade-off: two entries let one RAM fetch overlap one flash write; a deeper
  // buffer would not shorten an operation that the flash paces anyway.

  // Sequencer states; a program walks RD_LO, RD_HI, CAP and PUSH once per word.
  localparam ST_IDLE = 3'h0;
  localparam ST_RD_LO = 3'h1;
  localparam ST_RD_HI = 3'h2;
  localparam ST_CAP = 3'h3;
  localparam ST_PUSH = 3'h4;
  localparam ST_ERASE = 3'h5;
  localparam ST_DRAIN = 3'h6;

  // Software-visible registers, writable only while idle.
  reg [7:0] tgt_lo_ff;
  reg [7:0] tgt_hi_ff;
  reg [7:0] ram_lo_ff;
  reg [7:0] cnt_ff;

  // Sticky refusal flag and the one-cycle bus answer.
  reg refused_ff;
  reg ack_ff;

  // Sequencer state, stepping addresses, words left and the byte being paired.
  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [15:0] waddr_ff;
  reg [9:0] raddr_ff;
  reg [5:0] left_ff;
  reg [7:0] lo_byte_ff;
  reg [15:0] word_ff;

  // Decode, lock and buffer nets.
  wire lock_sync;
  wire req;
  wire [7:0] idx;
  wire wr_take;
  wire [15:0] target;
  wire in_lock;
  wire cmd_prog;
  wire cmd_erase;
  wire cmd_refuse;
  wire buf_in_valid;
  wire buf_in_ready;
  wire [`FISP_ENTRY_W-1:0] buf_in_data;
  wire [`FISP_ENTRY_W-1:0] buf_out_data;
  wire buf_empty;
  wire idle;

  // The lock option arrives as a static pin from outside the clock domain.
  fisp_sync3 u_lock_sync (
    .clk(clk),
    .reset(reset),
    .async_in(boot_region_lock_option),
    .sync_out(lock_sync)
  );

  // Words for the flash pass through a short buffer so a flash stall loses nothing.
  fisp_buf2 #(
    .WIDTH(`FISP_ENTRY_W)
  ) u_buf (
    .clk(clk),
    .reset(reset),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(flash_valid),
    .out_ready(flash_ready),
    .out_data(buf_out_data),
    .empty(buf_empty)
  );

  assign flash_erase = buf_out_data[32];
  assign flash_addr = buf_out_data[31:16];
  assign flash_wdata = buf_out_data[15:0];

  // Bus decode: every access answers one cycle after the request appears.
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_ff;
  assign idx = avs_address[9:2];
  assign wr_take = avs_write & ~ack_ff;
  assign idle = (state_ff == ST_IDLE);

  // Target word address and the locked-region test.
  assign target = {tgt_hi_ff, tgt_lo_ff};
  assign in_lock = (target >= `FISP_LOCK_LO) && (target <= `FISP_LOCK_HI);
  // Only the full upper region is guarded; option words stay open when unlocked.
  assign cmd_refuse = lock_sync & in_lock;
  assign cmd_prog = wr_take && idle && (idx == `FISP_IDX_CMD)
    && (avs_writedata[7:0] == `FISP_CMD_PROGRAM);
  assign cmd_erase = wr_take && idle && (idx == `FISP_IDX_CMD)
    && (avs_writedata[7:0] == `FISP_CMD_ERASE);

  // The core is held for the whole operation, including the final drain.
  assign cpu_hold = ~idle;

  // Buffer entries: one erase entry, or one assembled word per byte pair.
  assign buf_in_valid = (state_ff == ST_PUSH) || (state_ff == ST_ERASE);
  assign buf_in_data = (state_ff == ST_ERASE) ? {1'b1, waddr_ff, `FISP_ERASED_WORD}
    : {1'b0, waddr_ff, word_ff};

  // Register writes and the bus handshake; writes during an operation change nothing but the refusal flag.
  always @(posedge clk)
  begin
    if (reset)
    begin
      ack_ff <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      tgt_lo_ff <= `FISP_RST_BYTE;
      tgt_hi_ff <= `FISP_RST_BYTE;
      ram_lo_ff <= `FISP_RST_BYTE;
      cnt_ff <= `FISP_RST_BYTE;
      refused_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= req & ~ack_ff;
      // Read data are loaded in the first cycle, so they stand when waitrequest drops.
      if (avs_read && !ack_ff)
      begin
        case (idx)
          `FISP_IDX_TGT_LO: avs_readdata <= {24'h00_0000, tgt_lo_ff};
          `FISP_IDX_TGT_HI: avs_readdata <= {24'h00_0000, tgt_hi_ff};
          `FISP_IDX_RAM_LO: avs_readdata <= {24'h00_0000, ram_lo_ff};
          `FISP_IDX_CNT: avs_readdata <= {24'h00_0000, cnt_ff};
          `FISP_IDX_STATUS: avs_readdata <= {29'h0000_0000, lock_sync, refused_ff, ~idle};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
      // Writes land in the first cycle; the command register itself has no storage.
      if (wr_take && idle)
      begin
        case (idx)
          `FISP_IDX_TGT_LO: tgt_lo_ff <= avs_writedata[7:0];
          `FISP_IDX_TGT_HI: tgt_hi_ff <= avs_writedata[7:0];
          `FISP_IDX_RAM_LO: ram_lo_ff <= avs_writedata[7:0];
          `FISP_IDX_CNT: cnt_ff <= avs_writedata[7:0] & `FISP_CNT_MASK;
          default: cnt_ff <= cnt_ff;
        endcase
      end
      // A refusal in the same cycle as a clear keeps the flag set.
      if ((cmd_prog || cmd_erase) && cmd_refuse)
        refused_ff <= 1'b1;
      else if (wr_take && (idx == `FISP_IDX_STATUS) && avs_writedata[`FISP_ST_REFUSED])
        refused_ff <= 1'b0;
    end
  end

  // Sequencer state choice.
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (cmd_prog && !cmd_refuse)
          nxt_state = ST_RD_LO;
        else if (cmd_erase && !cmd_refuse)
          nxt_state = ST_ERASE;
      end
      ST_RD_LO: nxt_state = ST_RD_HI;
      ST_RD_HI: nxt_state = ST_CAP;
      ST_CAP: nxt_state = ST_PUSH;
      // PUSH holds while the buffer is full, so no word is lost to a stall.
      ST_PUSH:
      begin
        if (buf_in_ready)
          nxt_state = (left_ff == 6'h01) ? ST_DRAIN : ST_RD_LO;
      end
      ST_ERASE:
      begin
        if (buf_in_ready)
          nxt_state = ST_DRAIN;
      end
      ST_DRAIN:
      begin
        if (buf_empty)
          nxt_state = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // Sequencer datapath: RAM reads, byte pairing and address stepping.
  always @(posedge clk)
  begin
    if (reset)
    begin
      state_ff <= ST_IDLE;
      waddr_ff <= 16'h0000;
      raddr_ff <= 10'h000;
      left_ff <= 6'h00;
      lo_byte_ff <= 8'h00;
      word_ff <= 16'h0000;
      ram_rd_en <= 1'b0;
      ram_rd_addr <= 10'h000;
    end
    else
    begin
      state_ff <= nxt_state;
      ram_rd_en <= 1'b0;
      // Idle keeps reloading the start values, so the last register write always counts.
      if (state_ff == ST_IDLE)
      begin
        waddr_ff <= target;
        // Bit 9 of the source address has no storage, so it reads back as zero.
        raddr_ff <= {1'b0, cnt_ff[`FISP_CNT_RAM8], ram_lo_ff};
        left_ff <= {1'b0, cnt_ff[`FISP_CNT_MSB:`FISP_CNT_LSB]} + 6'h01;
      end
      // A read is issued on entry to RD_LO and to RD_HI, one byte each.
      if (nxt_state == ST_RD_LO || nxt_state == ST_RD_HI)
      begin
        ram_rd_en <= 1'b1;
        ram_rd_addr <= raddr_ff;
        raddr_ff <= raddr_ff + 10'h001;
      end
      // The first byte of the pair lands in the low half, the following byte in the high half.
      if (state_ff == ST_RD_HI)
        lo_byte_ff <= ram_rd_data;
      if (state_ff == ST_CAP)
        word_ff <= {ram_rd_data, lo_byte_ff};
      // Step to the next word only once the buffer has taken this one.
      if (state_ff == ST_PUSH && buf_in_ready)
      begin
        waddr_ff <= waddr_ff + 16'h0001;
        left_ff <= left_ff - 6'h01;
      end
    end
  end

endmodule

`default_nettype wire

//--- include/fisp_defs.vh
// Purpose: Constants for the flash page programmer: register indices, fields, codes, limits.
// Assumes: Register indices are multiplied by four to form Avalon byte addresses.
// Notes: Definitions only.
`ifndef FISP_DEFS_VH
`define FISP_DEFS_VH

// Register indices (byte address is four times the index).
`define FISP_IDX_CMD 8'hBA
`define FISP_IDX_TGT_LO 8'hBB
`define FISP_IDX_TGT_HI 8'hBC
`define FISP_IDX_RAM_LO 8'hBD
`define FISP_IDX_CNT 8'hBE
`define FISP_IDX_STATUS 8'hBF

// Reset values.
`define FISP_RST_BYTE 8'h00

// Command codes.
`define FISP_CMD_PROGRAM 8'h5A
`define FISP_CMD_ERASE 8'hC3

// Count register fields.
`define FISP_CNT_MSB 7
`define FISP_CNT_LSB 3
`define FISP_CNT_RAM8 0
`define FISP_CNT_MASK 8'hF9

// Status register fields.
`define FISP_ST_BUSY 0
`define FISP_ST_REFUSED 1
`define FISP_ST_LOCK 2

// Locked upper region of the flash.
`define FISP_LOCK_LO 16'h2000
`define FISP_LOCK_HI 16'h27FF

// Erased word value.
`define FISP_ERASED_WORD 16'hFFFF

// Width of one entry toward the flash: erase flag, word address, data.
`define FISP_ENTRY_W 33

`endif

//--- tb/fisp_flash_model.sv
// Purpose: Behavioural program flash array, 10K words of 16 bits.
// Assumes: One entry per accepted valid and ready.
// Notes: Ready stalls at random when slow is high.
`default_nettype none
module fisp_flash_model (
  // Clock and stall control
  input wire logic clk,
  input wire logic slow,
  // Flash port
  input wire logic flash_valid,
  output logic flash_ready,
  input wire logic flash_erase,
  input wire logic [15:0] flash_addr,
  input wire logic [15:0] flash_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [0:16'h27FF];
  initial
  begin
    foreach (mem[i]) mem[i] = 16'h0000;
    flash_ready = 1'b0;
  end
  // Erase clears a whole 128-word page in the one accepting cycle, with no added stall.
  always @(posedge clk)
  begin
    if (flash_valid && flash_ready)
    begin
      if (flash_erase)
        for (int i = 0; i < 128; i++) mem[flash_addr + i] = 16'hFFFF;
      else
        mem[flash_addr] = flash_wdata;
    end
    flash_ready <= slow ? 1'($urandom_range(0, 1)) : 1'b1;
  end
endmodule
`default_nettype wire

//--- tb/fisp_props.sv
// Purpose: Port checks for the flash page programmer.
// Assumes: Master holds requests; lock pin changes only while idle.
// Notes: Bound to fisp_top at the foot.
`include "fisp_defs.vh"
`default_nettype none
module fisp_props (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register bus
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Core, lock, RAM and flash
  input wire logic cpu_hold,
  input wire logic boot_region_lock_option,
  input wire logic ram_rd_en,
  input wire logic [9:0] ram_rd_addr,
  input wire logic flash_valid,
  input wire logic flash_ready,
  input wire logic flash_erase,
  input wire logic [15:0] flash_addr,
  input wire logic [15:0] flash_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  // A command write taken while idle.
  wire logic cmd_w = avs_write && avs_waitrequest && !cpu_hold && avs_address[9:2] == `FISP_IDX_CMD;
  wire logic [7:0] cd = avs_writedata[7:0];
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("Bus answer late.");
  a_read_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("Read data upper bits set.");
  a_bad_cmd: assert property (cmd_w && cd != `FISP_CMD_PROGRAM && cd != `FISP_CMD_ERASE |=> !cpu_hold[*2])
    else $error("Unknown command started work.");
  a_prog_start: assert property (cmd_w && cd == `FISP_CMD_PROGRAM && !boot_region_lock_option
    |=> cpu_hold ##[0:2] ram_rd_en) else $error("Program did not start.");
  a_erase_start: assert property (cmd_w && cd == `FISP_CMD_ERASE && !boot_region_lock_option
    |=> cpu_hold ##[0:2] (flash_valid && flash_erase)) else $error("Erase did not start.");
  a_erase_ones: assert property (flash_valid && flash_erase |-> flash_wdata == `FISP_ERASED_WORD)
    else $error("Erase word not all ones.");
  a_ram_pair: assert property ($rose(ram_rd_en) |=> ram_rd_en && ram_rd_addr == $past(ram_rd_addr) + 10'h1
    ##1 !ram_rd_en) else $error("RAM byte pair wrong.");
  a_entry_stable: assert property (flash_valid && !flash_ready |=> flash_valid && $stable(flash_addr)
    && $stable(flash_wdata) && $stable(flash_erase)) else $error("Flash entry changed while stalled.");
  a_core_held: assert property (flash_valid || ram_rd_en |-> cpu_hold)
    else $error("Core not held during work.");
  a_lock_region: assert property (boot_region_lock_option && flash_valid |-> flash_addr < `FISP_LOCK_LO)
    else $error("Locked region written.");
  c_prog: cover property (flash_valid && flash_ready && !flash_erase);
  c_erase: cover property (flash_valid && flash_erase);
  c_stall: cover property (flash_valid && !flash_ready);
endmodule
bind fisp_top fisp_props fisp_props_inst (.clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_readdata, .avs_waitrequest, .cpu_hold, .boot_region_lock_option, .ram_rd_en, .ram_rd_addr,
  .flash_valid, .flash_ready, .flash_erase, .flash_addr, .flash_wdata);
`default_nettype wire

//--- tb/fisp_top_tb.sv
// Purpose: Self-checking bench for the flash page programmer.
// Assumes: Data RAM answers one cycle after a read pulse.
// Notes: Random pages and counts from a fixed seed.
`include "fisp_defs.vh"
`default_nettype none
module fisp_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [9:0] avs_address = 10'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic lock = 1'b0;
  logic slow = 1'b0;
  logic [7:0] ram_rd_data = 8'h0;
  logic [7:0] ram [0:1023];
  logic [31:0] q;
  logic [7:0] d;
  logic [7:0] bad [4] = '{8'h00, 8'h5B, 8'hC2, 8'hFF};
  int fail_count = 0;
  int checks_done = 0;
  wire logic [31:0] avs_readdata;
  wire logic avs_waitrequest, cpu_hold, ram_rd_en, flash_valid, flash_ready, flash_erase;
  wire logic [9:0] ram_rd_addr;
  wire logic [15:0] flash_addr, flash_wdata;
  always #20 clk = ~clk;
  // RAM read port; the line shows the inverse when no read is answered.
  always @(posedge clk) ram_rd_data <= ram_rd_en ? ram[ram_rd_addr] : ~ram_rd_data;
  fisp_top fisp_top_inst (.clk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .cpu_hold, .boot_region_lock_option(lock), .ram_rd_en, .ram_rd_addr, .ram_rd_data,
    .flash_valid, .flash_ready, .flash_erase, .flash_addr, .flash_wdata);
  fisp_flash_model fisp_flash_model_inst (.clk, .slow, .flash_valid, .flash_ready, .flash_erase, .flash_addr,
    .flash_wdata);
  task automatic chk_bus(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_mem(input logic [15:0] a, input logic [15:0] e);
    chk_bus($sformatf("flash word %h", a), {16'h0, e}, {16'h0, fisp_flash_model_inst.mem[a]});
  endtask
  // One bus cycle; waitrequest is watched settled before the edge, read data are taken at the completing edge.
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= {idx, 2'h0};
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {24'h0, v};
    @(negedge clk);
    while (avs_waitrequest !== 1'b0 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    chk_bus("bus answer", 0, {31'h0, n == 20});
  endtask
  function automatic logic [15:0] exp_word(input logic [9:0] x, input int i);
    return {ram[x + 2 * i + 1], ram[x + 2 * i]};
  endfunction
  task automatic run(input logic [7:0] c, input logic [15:0] t, input logic [9:0] x, input logic [4:0] n,
    input logic go);
    int k;
    k = 0;
    bus(1'b1, `FISP_IDX_TGT_LO, t[7:0]);
    bus(1'b1, `FISP_IDX_TGT_HI, t[15:8]);
    bus(1'b1, `FISP_IDX_RAM_LO, x[7:0]);
    bus(1'b1, `FISP_IDX_CNT, {n, 2'h0, x[8]});
    // The bench plays software that has masked interrupts and cleared the watchdog just before.
    bus(1'b1, `FISP_IDX_CMD, c);
    @(negedge clk);
    chk_bus("cpu_hold", {31'h0, go}, {31'h0, cpu_hold});
    while (cpu_hold !== 1'b0 && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
    chk_bus("hold release", 0, {31'h0, k == 3000});
    $display("operation %h at %h done", c, t);
  endtask
  task automatic prog(input logic [15:0] t, input logic [9:0] x, input logic [4:0] n);
    logic [15:0] keep_w;
    keep_w = fisp_flash_model_inst.mem[t + n + 1];
    for (int i = 0; i < 64; i++) ram[x + i] = 8'($urandom);
    slow <= 1'($urandom);
    run(`FISP_CMD_PROGRAM, t, x, n, 1'b1);
    for (int i = 0; i <= n; i++) chk_mem(t + 16'(i), exp_word(x, i));
    if (n < 31) chk_mem(t + n + 1, keep_w);
  endtask
  task automatic erase(input logic [15:0] t);
    logic [15:0] keep_w;
    keep_w = fisp_flash_model_inst.mem[t + 128];
    run(`FISP_CMD_ERASE, t, 10'h0, 5'h0, 1'b1);
    for (int i = 0; i < 128; i++) chk_mem(t + 16'(i), `FISP_ERASED_WORD);
    chk_mem(t + 128, keep_w);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Watchdog well beyond the expected run length.
  initial
  begin
    repeat (60000) @(posedge clk);
    fail_count++;
    tally_and_finish;
  end
  initial
  begin
    void'($urandom(32'hF419953F));
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 'hBA; i <= 'hC0; i++)
    begin
      bus(1'b0, 8'(i), 8'h0);
      chk_bus("reset value", 0, q);
    end
    for (int i = 'hBB; i <= 'hBE; i++)
    begin
      d = 8'($urandom);
      bus(1'b1, 8'(i), d);
      bus(1'b0, 8'(i), 8'h0);
      chk_bus("register", {24'h0, i == 'hBE ? d & `FISP_CNT_MASK : d}, q);
    end
    bus(1'b1, 8'h10, 8'hA5);
    bus(1'b0, 8'h10, 8'h0);
    chk_bus("unmapped", 0, q);
    foreach (bad[k])
    begin
      bus(1'b1, `FISP_IDX_CMD, bad[k]);
      @(negedge clk);
      chk_bus("cpu_hold", 0, {31'h0, cpu_hold});
    end
    $display("register tests done");
    prog(16'h0040, 10'h100, 5'h1F);
    prog(16'h1FE0, 10'h03F, 5'h00);
    repeat (4) prog({3'h0, 8'($urandom), 5'h0}, 10'($urandom_range(0, 1) * 256 + $urandom_range(0, 63)), 5'($urandom));
    erase(16'h0000);
    erase(16'h1F80);
    lock <= 1'b1;
    repeat (6) @(posedge clk);
    prog(16'h1FE0, 10'h000, 5'h1F);
    run(`FISP_CMD_PROGRAM, 16'h2000, 10'h0, 5'h0, 1'b0);
    chk_mem(16'h2000, 16'h0000);
    run(`FISP_CMD_ERASE, 16'h2780, 10'h0, 5'h0, 1'b0);
    chk_mem(16'h27FF, 16'h0000);
    bus(1'b0, `FISP_IDX_STATUS, 8'h0);
    chk_bus("status", 32'h6, q);
    bus(1'b1, `FISP_IDX_STATUS, 8'h02);
    bus(1'b0, `FISP_IDX_STATUS, 8'h0);
    chk_bus("status", 32'h4, q);
    lock <= 1'b0;
    repeat (6) @(posedge clk);
    prog(16'h27E0, 10'h140, 5'h1F);
    tally_and_finish;
  end
endmodule
`default_nettype wire
